// ---- rtl/amei_pkg.sv ----
package amei_pkg;
   // register offsets
   localparam logic [4:0] OFS_ID = 5'h00;
   localparam logic [4:0] OFS_EVENT_ENABLE = 5'h01;
   localparam logic [4:0] OFS_EVENT_MAP = 5'h02;
   localparam logic [4:0] OFS_STATUS = 5'h03;
   localparam logic [4:0] OFS_KNOCK_LEVEL = 5'h04;
   localparam logic [4:0] OFS_KNOCK_MAX_LENGTH = 5'h05;
   localparam logic [4:0] OFS_KNOCK_LATENCY = 5'h06;
   localparam logic [4:0] OFS_KNOCK_WINDOW = 5'h07;
   localparam logic [4:0] OFS_MOTION_LEVEL = 5'h08;
   localparam logic [4:0] OFS_STILL_LEVEL = 5'h09;
   localparam logic [4:0] OFS_STILL_TIME = 5'h0a;
   localparam logic [4:0] OFS_MOTION_CTL = 5'h0b;
   localparam logic [4:0] OFS_DROP_LEVEL = 5'h0c;
   localparam logic [4:0] OFS_DROP_TIME = 5'h0d;
   localparam logic [4:0] OFS_FIFO_CTL = 5'h0e;
   localparam logic [4:0] OFS_FIFO_STATUS = 5'h0f;
   localparam logic [4:0] OFS_X_OUT = 5'h10;
   localparam logic [4:0] OFS_Y_OUT = 5'h11;
   localparam logic [4:0] OFS_Z_OUT = 5'h12;
   localparam logic [4:0] OFS_RANGE = 5'h13;
   // event bit positions, shared by status, enable and map
   localparam int EV_NEW_SAMPLE = 0;
   localparam int EV_ONE_KNOCK = 1;
   localparam int EV_TWO_KNOCK = 2;
   localparam int EV_MOTION = 3;
   localparam int EV_STILL = 4;
   localparam int EV_DROP = 5;
   localparam int EV_WATERMARK = 6;
   localparam int EV_OVERRUN = 7;
   localparam logic [7:0] LIVE_MASK = 8'hc1; // flags derived from data state
   // motion_ctl fields
   localparam int MC_MOTION_AC = 7;
   localparam int MC_MOTION_AXES = 4;
   localparam int MC_STILL_AC = 3;
   localparam int MC_STILL_AXES = 0;
   // fifo_ctl fields: mode in [7:6], sample count in [5:0]
   localparam int FC_MODE = 6;
   localparam logic [1:0] MODE_BYPASS = 2'h0;
   localparam logic [1:0] MODE_FIFO = 2'h1;
   localparam logic [1:0] MODE_STREAM = 2'h2;
   localparam logic [1:0] MODE_TRIGGER = 2'h3;
   // thresholds count in 16-sample-count steps
   localparam int THR_SHIFT = 4;
   // full-scale magnitude per range code, in 4 mg counts
   localparam logic [12:0] FS_2G = 13'h01ff;
   localparam logic [12:0] FS_4G = 13'h03ff;
   localparam logic [12:0] FS_8G = 13'h07ff;
   localparam logic [12:0] FS_16G = 13'h0fff;
   // timer step sizes in ns, and clock period
   localparam longint CLK_PERIOD_NS = 100;
   localparam longint KNOCK_STEP_NS = 625000;
   localparam longint GAP_STEP_NS = 1250000;
   localparam longint DROP_STEP_NS = 5000000;
   localparam longint STILL_STEP_NS = 1000000000;
   localparam int KNOCK_STEP_CYC = int'(KNOCK_STEP_NS / CLK_PERIOD_NS);
   localparam int GAP_STEP_CYC = int'(GAP_STEP_NS / CLK_PERIOD_NS);
   localparam int DROP_STEP_CYC = int'(DROP_STEP_NS / CLK_PERIOD_NS);
   localparam int STILL_STEP_CYC = int'(STILL_STEP_NS / CLK_PERIOD_NS);
   localparam logic [7:0] ID_VALUE = 8'h5a; // arbitrary identity value
endpackage : amei_pkg

// ---- rtl/amei_event_ctrl.sv ----
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module amei_event_ctrl #(
   parameter int SAMPLE_W = 13,
   parameter int DEPTH = 32,
   parameter int KNOCK_STEP_CYC = amei_pkg::KNOCK_STEP_CYC,
   parameter int GAP_STEP_CYC = amei_pkg::GAP_STEP_CYC,
   parameter int DROP_STEP_CYC = amei_pkg::DROP_STEP_CYC,
   parameter int STILL_STEP_CYC = amei_pkg::STILL_STEP_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sample_valid,
   input wire logic signed [SAMPLE_W-1:0] x_in,
   input wire logic signed [SAMPLE_W-1:0] y_in,
   input wire logic signed [SAMPLE_W-1:0] z_in,
   input wire logic trigger_in,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic first_event_pin,
   output logic second_event_pin,
   output logic irq
);
   localparam int PW = $clog2(DEPTH);

   // the datapath assumes 13-bit samples and a power-of-two queue of at most 63
   if (SAMPLE_W != 13 || DEPTH < 2 || DEPTH > 63 || (1 << PW) != DEPTH) begin : g_bad_size
      $error("amei_event_ctrl: unsupported SAMPLE_W or DEPTH");
   end
   if (KNOCK_STEP_CYC < 1 || GAP_STEP_CYC < 1 ||
       DROP_STEP_CYC < 1 || STILL_STEP_CYC < 1) begin : g_bad_step
      $error("amei_event_ctrl: step counts must be at least one");
   end

   typedef enum logic [2:0] {K_IDLE, K_HIGH, K_LATENT, K_WINDOW, K_WAIT_LOW} amei_knock_t;

   // configuration registers
   logic [7:0] event_enable_r, event_map_r, status_r;
   logic [7:0] knock_level_r, knock_max_length_r, knock_latency_r, knock_window_r;
   logic [7:0] motion_level_r, still_level_r, still_time_r, motion_ctl_r;
   logic [7:0] drop_level_r, drop_time_r, fifo_ctl_r;
   logic [1:0] range_r;
   logic [15:0] rdata_r;
   logic first_pin_r, second_pin_r, irq_r;

   // sample datapath
   logic signed [12:0] cur [3];
   logic [13:0] mag_cur [3], mag_act [3], mag_still [3];
   logic signed [12:0] act_ref_r [3], still_ref_r [3];
   logic act_arm_r, act_en_d_r;
   logic [2:0] act_ax, still_ax;
   logic knock_hi, act_hit, still_hit, drop_hit, still_exceed;
   logic [7:0] evt;
   logic [3:0] tick;

   // queue and output holding
   logic [3*13-1:0] mem [DEPTH];
   logic [PW-1:0] wptr_r, rptr_r;
   logic [PW:0] cnt_r;
   logic signed [12:0] hold_r [3];
   logic unread_r, byp_ovr_r, trig_seen_r;
   logic [1:0] mode;
   logic bypass, full, pop, push, overwrite;
   logic [7:0] live;

   // knock detector
   amei_knock_t kst_r;
   logic [7:0] kcnt_r;
   logic second_r;

   function automatic logic [13:0] mag(input logic signed [13:0] v);
      mag = v[13] ? 14'(-v) : 14'(v);
   endfunction : mag

   function automatic logic signed [12:0] clamp(input logic signed [12:0] v,
                                                input logic [12:0] fs);
      if (v > $signed(fs))
         clamp = $signed(fs);
      else if (v < -$signed(fs))
         clamp = -$signed(fs);
      else
         clamp = v;
   endfunction : clamp

   function automatic logic over(input logic [13:0] m, input logic [7:0] thr);
      over = m > {2'h0, thr, 4'h0};
   endfunction : over

   assign mode = fifo_ctl_r[amei_pkg::FC_MODE +: 2];
   assign bypass = mode == amei_pkg::MODE_BYPASS;
   assign full = cnt_r == (PW+1)'(DEPTH);
   assign act_ax = motion_ctl_r[amei_pkg::MC_MOTION_AXES +: 3];
   assign still_ax = motion_ctl_r[amei_pkg::MC_STILL_AXES +: 3];

   // range clamp and per-axis magnitudes; the scale stays 4 mg per count
   always_comb begin
      logic [12:0] fs;
      fs = amei_pkg::FS_16G;
      case (range_r)
         2'h0: fs = amei_pkg::FS_2G;
         2'h1: fs = amei_pkg::FS_4G;
         2'h2: fs = amei_pkg::FS_8G;
         default: fs = amei_pkg::FS_16G;
      endcase
      cur[0] = clamp(x_in, fs);
      cur[1] = clamp(y_in, fs);
      cur[2] = clamp(z_in, fs);
      for (int a = 0; a < 3; a++) begin
         mag_cur[a] = mag(14'(cur[a]));
         mag_act[a] = mag(14'(cur[a]) - 14'(act_ref_r[a]));
         mag_still[a] = mag(14'(cur[a]) - 14'(still_ref_r[a]));
      end
   end

   // comparisons: coupling picks raw or reference-relative magnitude
   always_comb begin
      knock_hi = 1'b0;
      act_hit = 1'b0;
      still_hit = still_ax != 3'h0;
      still_exceed = 1'b0;
      drop_hit = 1'b1;
      for (int a = 0; a < 3; a++) begin
         knock_hi = knock_hi | over(mag_cur[a], knock_level_r);
         if (act_ax[a]) begin
            if (motion_ctl_r[amei_pkg::MC_MOTION_AC])
               act_hit = act_hit | over(mag_act[a], motion_level_r);
            else
               act_hit = act_hit | over(mag_cur[a], motion_level_r);
         end
         if (still_ax[a]) begin
            if (motion_ctl_r[amei_pkg::MC_STILL_AC])
               still_exceed = still_exceed | over(mag_still[a], still_level_r);
            else
               still_exceed = still_exceed | over(mag_cur[a], still_level_r);
         end
         // drop always looks at every axis, dc only
         drop_hit = drop_hit & ~over(mag_cur[a], drop_level_r);
      end
      still_hit = still_hit & ~still_exceed;
   end

   // timer step strobes, one divider each
   generate
      for (genvar g = 0; g < 4; g++) begin : g_div
         localparam int PER = (g == 0) ? KNOCK_STEP_CYC : (g == 1) ? GAP_STEP_CYC :
                              (g == 2) ? DROP_STEP_CYC : STILL_STEP_CYC;
         logic [31:0] dcnt_r;
         always_ff @(posedge ref_clk) begin
            if (reset || dcnt_r == 32'(PER - 1))
               dcnt_r <= 32'h0;
            else
               dcnt_r <= dcnt_r + 32'h1;
         end
         assign tick[g] = dcnt_r == 32'(PER - 1);
      end
   endgenerate

   // stillness and drop duration timers, identical structure
   logic [1:0] dur_evt;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_dur
         logic cond_r, fired_r;
         logic [7:0] tcnt_r;
         wire logic step = (g == 0) ? tick[3] : tick[2];
         wire logic [7:0] limit = (g == 0) ? still_time_r : drop_time_r;
         wire logic hit = (g == 0) ? still_hit : drop_hit;
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               cond_r <= 1'b0;
               fired_r <= 1'b0;
               tcnt_r <= 8'h0;
            end else begin
               if (sample_valid)
                  cond_r <= hit;
               if (!cond_r || (sample_valid && !hit)) begin
                  tcnt_r <= 8'h0;
                  fired_r <= 1'b0;
               end else if (step && !fired_r) begin
                  // fires on the step after the limit: strictly longer than it
                  if (tcnt_r >= limit)
                     fired_r <= 1'b1;
                  else
                     tcnt_r <= tcnt_r + 8'h1;
               end
            end
         end
         assign dur_evt[g] = cond_r && !(sample_valid && !hit) && step && !fired_r &&
                             tcnt_r >= limit;
      end
   endgenerate

   // ac references: motion latches at start, stillness refreshes on exceed
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         act_arm_r <= 1'b1;
         act_en_d_r <= 1'b0;
         for (int a = 0; a < 3; a++) begin
            act_ref_r[a] <= 13'h0000;
            still_ref_r[a] <= 13'h0000;
         end
      end else begin
         act_en_d_r <= event_enable_r[amei_pkg::EV_MOTION];
         if (event_enable_r[amei_pkg::EV_MOTION] && !act_en_d_r)
            act_arm_r <= 1'b1;
         else if (sample_valid && act_arm_r) begin
            act_arm_r <= 1'b0;
            for (int a = 0; a < 3; a++)
               act_ref_r[a] <= cur[a];
         end
         if (sample_valid && still_exceed) begin
            for (int a = 0; a < 3; a++)
               still_ref_r[a] <= cur[a];
         end
      end
   end

   // knock sequencer: duration, latency and window
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         kst_r <= K_IDLE;
         kcnt_r <= 8'h0;
         second_r <= 1'b0;
      end else begin
         case (kst_r)
            K_IDLE: begin
               if (sample_valid && knock_hi) begin
                  kst_r <= K_HIGH;
                  kcnt_r <= 8'h0;
                  second_r <= 1'b0;
               end
            end
            K_HIGH: begin
               if (sample_valid && !knock_hi) begin
                  kcnt_r <= 8'h0;
                  if (!second_r && knock_latency_r != 8'h0 && knock_window_r != 8'h0)
                     kst_r <= K_LATENT;
                  else
                     kst_r <= K_IDLE;
               end else if (kcnt_r >= knock_max_length_r)
                  kst_r <= K_WAIT_LOW; // too long for a knock
               else if (tick[0])
                  kcnt_r <= kcnt_r + 8'h1;
            end
            K_LATENT: begin
               // motion during latency is ignored, it is ringing of the first knock
               if (kcnt_r >= knock_latency_r) begin
                  kst_r <= K_WINDOW;
                  kcnt_r <= 8'h0;
               end else if (tick[1])
                  kcnt_r <= kcnt_r + 8'h1;
            end
            K_WINDOW: begin
               if (sample_valid && knock_hi) begin
                  kst_r <= K_HIGH;
                  kcnt_r <= 8'h0;
                  second_r <= 1'b1;
               end else if (kcnt_r >= knock_window_r)
                  kst_r <= K_IDLE;
               else if (tick[1])
                  kcnt_r <= kcnt_r + 8'h1;
            end
            K_WAIT_LOW: begin
               if (sample_valid && !knock_hi)
                  kst_r <= K_IDLE;
            end
            default: kst_r <= K_IDLE;
         endcase
      end
   end

   // one-cycle event pulses feeding the sticky flags
   always_comb begin
      logic knock_end;
      knock_end = kst_r == K_HIGH && sample_valid && !knock_hi &&
                  kcnt_r < knock_max_length_r;
      evt = 8'h00;
      evt[amei_pkg::EV_ONE_KNOCK] = knock_end && !second_r;
      evt[amei_pkg::EV_TWO_KNOCK] = knock_end && second_r;
      evt[amei_pkg::EV_MOTION] = sample_valid && act_hit && !act_arm_r;
      evt[amei_pkg::EV_STILL] = dur_evt[0];
      evt[amei_pkg::EV_DROP] = dur_evt[1];
   end

   // queue control; trigger mode streams until the trigger, then fills and stops
   assign pop = rd && addr == amei_pkg::OFS_Z_OUT;
   assign overwrite = full && !pop &&
                      (mode == amei_pkg::MODE_STREAM ||
                       (mode == amei_pkg::MODE_TRIGGER && !trig_seen_r));
   assign push = sample_valid && !bypass && (!full || overwrite || pop);

   always_ff @(posedge ref_clk) begin
      if (push)
         mem[wptr_r] <= {cur[2], cur[1], cur[0]};
   end

   always_ff @(posedge ref_clk) begin
      if (reset || bypass) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push)
            wptr_r <= wptr_r + PW'(1);
         if ((pop && cnt_r != '0) || (push && overwrite))
            rptr_r <= rptr_r + PW'(1);
         if (push && !overwrite && !(pop && cnt_r != '0))
            cnt_r <= cnt_r + (PW+1)'(1);
         else if (!push && pop && cnt_r != '0)
            cnt_r <= cnt_r - (PW+1)'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || mode != amei_pkg::MODE_TRIGGER)
         trig_seen_r <= 1'b0;
      else if (trigger_in)
         trig_seen_r <= 1'b1;
   end

   // bypass output holding and its overwrite detection; set wins over read
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         unread_r <= 1'b0;
         byp_ovr_r <= 1'b0;
         for (int a = 0; a < 3; a++)
            hold_r[a] <= 13'h0000;
      end else if (sample_valid && bypass) begin
         for (int a = 0; a < 3; a++)
            hold_r[a] <= cur[a];
         unread_r <= 1'b1;
         if (unread_r && !pop)
            byp_ovr_r <= 1'b1;
      end else if (pop || !bypass) begin
         unread_r <= 1'b0;
         byp_ovr_r <= 1'b0;
      end
   end

   // live flags follow data state and clear themselves
   always_comb begin
      live = 8'h00;
      live[amei_pkg::EV_NEW_SAMPLE] = bypass ? unread_r : cnt_r != '0;
      live[amei_pkg::EV_WATERMARK] = !bypass && fifo_ctl_r[5:0] != 6'h0 &&
                                     cnt_r >= (PW+1)'(fifo_ctl_r[5:0]);
      live[amei_pkg::EV_OVERRUN] = bypass ? byp_ovr_r : full;
   end

   // sticky flags cleared by writing one; a new event wins over the clear
   always_ff @(posedge ref_clk) begin
      if (reset)
         status_r <= 8'h00;
      else if (wr && addr == amei_pkg::OFS_STATUS)
         status_r <= ((status_r & ~wdata) | evt) & ~amei_pkg::LIVE_MASK;
      else
         status_r <= (status_r | evt) & ~amei_pkg::LIVE_MASK;
   end

   // pin routing and summary interrupt
   always_ff @(posedge ref_clk) begin
      logic [7:0] act;
      act = (status_r | live) & event_enable_r;
      if (reset) begin
         first_pin_r <= 1'b0;
         second_pin_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         first_pin_r <= |(act & ~event_map_r);
         second_pin_r <= |(act & event_map_r);
         irq_r <= |act;
      end
   end

   // register writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         event_enable_r <= 8'h00;
         event_map_r <= 8'h00;
         knock_level_r <= 8'h00;
         knock_max_length_r <= 8'h00;
         knock_latency_r <= 8'h00;
         knock_window_r <= 8'h00;
         motion_level_r <= 8'h00;
         still_level_r <= 8'h00;
         still_time_r <= 8'h00;
         motion_ctl_r <= 8'h00;
         drop_level_r <= 8'h00;
         drop_time_r <= 8'h00;
         fifo_ctl_r <= 8'h00;
         range_r <= 2'h3;
      end else if (wr) begin
         case (addr)
            amei_pkg::OFS_EVENT_ENABLE: event_enable_r <= wdata;
            amei_pkg::OFS_EVENT_MAP: event_map_r <= wdata;
            amei_pkg::OFS_KNOCK_LEVEL: knock_level_r <= wdata;
            amei_pkg::OFS_KNOCK_MAX_LENGTH: knock_max_length_r <= wdata;
            amei_pkg::OFS_KNOCK_LATENCY: knock_latency_r <= wdata;
            amei_pkg::OFS_KNOCK_WINDOW: knock_window_r <= wdata;
            amei_pkg::OFS_MOTION_LEVEL: motion_level_r <= wdata;
            amei_pkg::OFS_STILL_LEVEL: still_level_r <= wdata;
            amei_pkg::OFS_STILL_TIME: still_time_r <= wdata;
            amei_pkg::OFS_MOTION_CTL: motion_ctl_r <= wdata;
            amei_pkg::OFS_DROP_LEVEL: drop_level_r <= wdata;
            amei_pkg::OFS_DROP_TIME: drop_time_r <= wdata;
            amei_pkg::OFS_FIFO_CTL: fifo_ctl_r <= wdata;
            amei_pkg::OFS_RANGE: range_r <= wdata[1:0];
            default: ;
         endcase
      end
   end

   // read data, valid the cycle after rd; unmapped reads return zero
   always_ff @(posedge ref_clk) begin
      logic [3*13-1:0] head;
      head = bypass ? {hold_r[2], hold_r[1], hold_r[0]} : mem[rptr_r];
      if (reset)
         rdata_r <= 16'h0000;
      else if (rd) begin
         case (addr)
            amei_pkg::OFS_ID: rdata_r <= {8'h00, amei_pkg::ID_VALUE};
            amei_pkg::OFS_EVENT_ENABLE: rdata_r <= {8'h00, event_enable_r};
            amei_pkg::OFS_EVENT_MAP: rdata_r <= {8'h00, event_map_r};
            amei_pkg::OFS_STATUS: rdata_r <= {8'h00, status_r | live};
            amei_pkg::OFS_KNOCK_LEVEL: rdata_r <= {8'h00, knock_level_r};
            amei_pkg::OFS_KNOCK_MAX_LENGTH: rdata_r <= {8'h00, knock_max_length_r};
            amei_pkg::OFS_KNOCK_LATENCY: rdata_r <= {8'h00, knock_latency_r};
            amei_pkg::OFS_KNOCK_WINDOW: rdata_r <= {8'h00, knock_window_r};
            amei_pkg::OFS_MOTION_LEVEL: rdata_r <= {8'h00, motion_level_r};
            amei_pkg::OFS_STILL_LEVEL: rdata_r <= {8'h00, still_level_r};
            amei_pkg::OFS_STILL_TIME: rdata_r <= {8'h00, still_time_r};
            amei_pkg::OFS_MOTION_CTL: rdata_r <= {8'h00, motion_ctl_r};
            amei_pkg::OFS_DROP_LEVEL: rdata_r <= {8'h00, drop_level_r};
            amei_pkg::OFS_DROP_TIME: rdata_r <= {8'h00, drop_time_r};
            amei_pkg::OFS_FIFO_CTL: rdata_r <= {8'h00, fifo_ctl_r};
            amei_pkg::OFS_FIFO_STATUS: rdata_r <= 16'(cnt_r);
            amei_pkg::OFS_X_OUT: rdata_r <= 16'(signed'(head[12:0]));
            amei_pkg::OFS_Y_OUT: rdata_r <= 16'(signed'(head[25:13]));
            amei_pkg::OFS_Z_OUT: rdata_r <= 16'(signed'(head[38:26]));
            amei_pkg::OFS_RANGE: rdata_r <= {14'h0000, range_r};
            default: rdata_r <= 16'h0000;
         endcase
      end
   end

   assign rdata = rdata_r;
   assign first_event_pin = first_pin_r;
   assign second_event_pin = second_pin_r;
   assign irq = irq_r;
endmodule : amei_event_ctrl

// ---- testbench/amei_event_ctrl_checker.sv ----
`timescale 1ns/100ps
module amei_event_ctrl_checker #(parameter int DEPTH = 32) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [4:0] addr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic first_event_pin,
   input wire logic second_event_pin,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // a read answer belongs to the strobe one cycle back
   property p_rst; $fell(reset) |-> !(irq || first_event_pin || second_event_pin); endproperty
   a_rst: assert property (p_rst) else $error("output busy after reset");
   property p_pin; first_event_pin || second_event_pin |-> irq; endproperty
   a_pin: assert property (p_pin) else $error("pin high without irq");
   property p_quiet; rd && addr == amei_pkg::OFS_STATUS ##1 rdata == 16'h0000 |-> !irq; endproperty
   a_quiet: assert property (p_quiet) else $error("irq with clear status");
   property p_hold; !rd |=> $stable(rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unmap; rd && addr > amei_pkg::OFS_RANGE |=> rdata == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_id; rd && addr == amei_pkg::OFS_ID |=> rdata == {8'h00, amei_pkg::ID_VALUE}; endproperty
   a_id: assert property (p_id) else $error("identity wrong");
   property p_sext; rd && addr inside {[amei_pkg::OFS_X_OUT:amei_pkg::OFS_Z_OUT]}
      |=> rdata[15:13] == {3{rdata[12]}}; endproperty
   a_sext: assert property (p_sext) else $error("sample not sign extended");
   property p_fill; rd && addr == amei_pkg::OFS_FIFO_STATUS |=> rdata <= 16'(DEPTH); endproperty
   a_fill: assert property (p_fill) else $error("fill above depth");
   c_irq: cover property ($rose(irq));
   c_pin2: cover property ($rose(second_event_pin));
   c_full: cover property (rd && addr == amei_pkg::OFS_FIFO_STATUS ##1 rdata == 16'(DEPTH));
endmodule : amei_event_ctrl_checker
bind amei_event_ctrl amei_event_ctrl_checker #(.DEPTH(DEPTH)) u_chk (.*);

// ---- testbench/amei_host_model.sv ----
`timescale 1ns/100ps
module amei_host_model (
   input wire logic ref_clk,
   output logic [4:0] addr = 5'h00,
   output logic [7:0] wdata = 8'h00,
   output logic wr = 1'b0,
   output logic rd = 1'b0
);
   // one strobe per call, then idle, so no strobe is set twice in a step
   task automatic access(logic [4:0] a, logic [7:0] d, logic w);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge ref_clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : access
endmodule : amei_host_model

// ---- testbench/tb_amei_event_ctrl.sv ----
`timescale 1ns/100ps
module tb_amei_event_ctrl;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic sample_valid = 1'b0;
   logic trigger_in = 1'b0;
   logic signed [12:0] x_in = 13'h0000, y_in = 13'h0000, z_in = 13'h0000;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic wr, rd, rd_q = 1'b0;
   logic [15:0] rdata;
   logic first_event_pin, second_event_pin, irq;
   logic [15:0] exp_q[$];
   int lx, ly, lz;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   always #50 ref_clk = ~ref_clk;
   amei_host_model u_host (.*);
   // short step counts keep timed events inside a brief run
   amei_event_ctrl #(.KNOCK_STEP_CYC(4), .GAP_STEP_CYC(4), .DROP_STEP_CYC(4),
      .STILL_STEP_CYC(4)) u_dut (.*);
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rd_exp(logic [4:0] a, logic [15:0] e);
      exp_q.push_back(e);
      u_host.access(a, 8'h00, 1'b0);
   endtask : rd_exp
   task automatic put(int x, int y, int z);
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      {x_in, y_in, z_in} <= {13'(x), 13'(y), 13'(z)};
      {lx, ly, lz} = {x, y, z};
      @(posedge ref_clk);
      sample_valid <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : put
   task automatic get();
      rd_exp(amei_pkg::OFS_X_OUT, 16'(lx));
      rd_exp(amei_pkg::OFS_Y_OUT, 16'(ly));
      rd_exp(amei_pkg::OFS_Z_OUT, 16'(lz));
   endtask : get
   // irq, second pin, first pin; a step past the edge so they have settled
   task automatic pins(logic [2:0] e);
      #1;
      chk("pins", {13'h0000, irq, second_event_pin, first_event_pin}, {13'h0000, e});
   endtask : pins
   // each read answer is paired with the oldest note
   always @(posedge ref_clk) begin
      if (rd_q)
         chk("rdata", rdata, exp_q.pop_front());
      rd_q <= rd;
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(79237));
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      rd_exp(amei_pkg::OFS_ID, {8'h00, amei_pkg::ID_VALUE});
      rd_exp(5'h1f, 16'h0000);
      // knock level out of reach, watermark out of reach in bypass
      u_host.access(amei_pkg::OFS_KNOCK_LEVEL, 8'hff, 1'b1);
      u_host.access(amei_pkg::OFS_FIFO_CTL, 8'h1f, 1'b1);
      u_host.access(amei_pkg::OFS_EVENT_ENABLE, 8'hc9, 1'b1);
      u_host.access(amei_pkg::OFS_EVENT_MAP, 8'h08, 1'b1);
      u_host.access(amei_pkg::OFS_MOTION_LEVEL, 8'h01, 1'b1);
      put($urandom_range(8000) - 4000, $urandom_range(8000) - 4000, 7);
      pins(3'h5);
      put(-9, $urandom_range(8000) - 4000, $urandom_range(8000) - 4000);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0081);
      get();
      rd_exp(amei_pkg::OFS_STATUS, 16'h0000);
      pins(3'h0);
      // only z takes part, so a large x alone stays quiet
      u_host.access(amei_pkg::OFS_MOTION_CTL, 8'h40, 1'b1);
      put(0, 0, 1);
      get();
      put(100, 0, 0);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0001);
      get();
      put(0, 0, 100);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0009);
      pins(3'h7);
      get();
      u_host.access(amei_pkg::OFS_STATUS, 8'h08, 1'b1);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0000);
      pins(3'h0);
      // motion off and on, so the next sample becomes the ac reference
      u_host.access(amei_pkg::OFS_EVENT_ENABLE, 8'hc1, 1'b1);
      u_host.access(amei_pkg::OFS_MOTION_CTL, 8'h00, 1'b1);
      u_host.access(amei_pkg::OFS_EVENT_ENABLE, 8'hc9, 1'b1);
      u_host.access(amei_pkg::OFS_MOTION_CTL, 8'hc0, 1'b1);
      put(0, 0, 200);
      get();
      put(0, 0, 210);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0001);
      get();
      put(0, 0, 230);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0009);
      get();
      u_host.access(amei_pkg::OFS_STATUS, 8'h08, 1'b1);
      u_host.access(amei_pkg::OFS_MOTION_CTL, 8'h00, 1'b1);
      // short knock: high sample, quiet one well inside the length limit
      u_host.access(amei_pkg::OFS_KNOCK_MAX_LENGTH, 8'h08, 1'b1);
      u_host.access(amei_pkg::OFS_KNOCK_LEVEL, 8'h01, 1'b1);
      put(0, 0, 100);
      get();
      put(0, 0, 1);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0003);
      get();
      u_host.access(amei_pkg::OFS_STATUS, 8'h02, 1'b1);
      u_host.access(amei_pkg::OFS_KNOCK_LEVEL, 8'hff, 1'b1);
      // all axes at rest: drop fires on the first step, limit zero
      put(0, 0, 0);
      rd_exp(amei_pkg::OFS_STATUS, 16'h0021);
      get();
      u_host.access(amei_pkg::OFS_STATUS, 8'h20, 1'b1);
      // fifo mode with watermark two: fill to the brim, drain in order
      u_host.access(amei_pkg::OFS_FIFO_CTL, 8'h42, 1'b1);
      for (int k = 1; k <= 32; k++) begin
         put(k, -k, k);
         if (k <= 2)
            rd_exp(amei_pkg::OFS_STATUS, (k == 1) ? 16'h0001 : 16'h0041);
      end
      rd_exp(amei_pkg::OFS_STATUS, 16'h00c1);
      rd_exp(amei_pkg::OFS_FIFO_STATUS, 16'h0020);
      for (int k = 1; k <= 32; k++) begin
         {lx, ly, lz} = {k, -k, k};
         get();
         if (k == 1 || k == 31)
            rd_exp(amei_pkg::OFS_STATUS, (k == 1) ? 16'h0041 : 16'h0001);
      end
      rd_exp(amei_pkg::OFS_STATUS, 16'h0000);
      repeat (4) @(posedge ref_clk);
      end_sim();
   end
endmodule : tb_amei_event_ctrl
